//--- spi_port_pkg.sv
// Shared constants and carriers for the serial peripheral port.
// Assumes a single bus clock domain.
package spi_port_pkg;
   localparam int DATA_W = 8;
   localparam int PRE_W = 3;
   localparam int RATE_W = 3;
   localparam int BIT_CNT_W = 4;
   localparam logic [BIT_CNT_W-1:0] BITS_PER_XFER = 4'h8;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam int FIFO_DEPTH = 4;
   // Slave edge filter depth (synchroniser stages)
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_TRAIL = 2'b10
   } xfer_state_t;

   // Configuration bits steering the port
   typedef struct packed {
      logic module_enable;
      logic master_mode;
      logic single_wire_select;
      logic bidir_output_enable;
      logic mode_fault_enable;
      logic select_output_enable;
      logic [PRE_W-1:0] prescale_select;
      logic [RATE_W-1:0] rate_select;
   } cfg_t;

   // One pin's drive: level and output enable
   typedef struct packed {
      logic o;
      logic oe;
   } pin_drv_t;
endpackage

//--- spi_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and a clock enable.
`timescale 1ns/1ps
module spi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic flush,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign o_valid = (cnt_reg != '0);
   assign o_data = mem[rd_reg];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wr_reg] <= i_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || (ce && flush)) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else if (ce) begin
         if (push) begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- spi_port.sv
// Serial peripheral port: master or slave, full duplex or single wire.
// Assumes bus-side write/read strobes on I_CLK; pins enter unsynchronised.
//
// Function
// - Master bit rate at most clock/2, slave at most clock/4.
// - Prescaler divides bus clock by 1 to 8 per prescale_select.
// - Rate divider divides prescaler output by 2 to 256.
// - Master starts transfers; both shifters exchange contents.
// - Written byte waits in transmit buffer until transfer start.
// - Completed byte moves to receive buffer read via data register.
// - Master drives clock and MOSI, samples MISO.
// - Slave clocks from pin, drives MISO, samples MOSI.
// - Disabled module releases all four pins.
// - Master single wire uses MOSI bidirectionally, releases MISO.
// - Slave single wire uses MISO bidirectionally, releases MOSI.
// - Slave select is active-low input in slave role.
// - Master select pin: free, mode fault input, or select output.
// - Inactive in stop modes; deep stop returns reset state.
// - Light stop holds state; reset exit resets, else resumes.
// - Software view is five 8-bit registers.
// - Disable stops transfer, flushes buffers, flags reset.
`timescale 1ns/1ps
module spi_port #(
   parameter int FIFO_D = spi_port_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   // Configuration
   input wire spi_port_pkg::cfg_t I_CFG,
   // Data register access
   input wire logic I_WR,
   input wire logic [spi_port_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_RD,
   output logic [spi_port_pkg::DATA_W-1:0] O_RDATA,
   // Status
   output logic O_TX_EMPTY,
   output logic O_TX_READY,
   output logic O_RX_FULL,
   output logic O_MODE_FAULT,
   output logic O_BUSY,
   // Serial clock pin
   input wire logic I_SCK,
   output logic O_SCK,
   output logic O_SCK_OE,
   // MOSI pin
   input wire logic I_MOSI,
   output logic O_MOSI,
   output logic O_MOSI_OE,
   // MISO pin
   input wire logic I_MISO,
   output logic O_MISO,
   output logic O_MISO_OE,
   // Slave select pin
   input wire logic I_SS_N,
   output logic O_SS_N,
   output logic O_SS_N_OE
);
   localparam int DW = spi_port_pkg::DATA_W;
   localparam int CW = spi_port_pkg::BIT_CNT_W;

   // Every check below runs on the bus clock
   default clocking chk_cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Stop modes gate I_CE; deep stop is modelled by reset
   logic [1:0] sck_s;
   logic [1:0] mosi_s;
   logic [1:0] miso_s;
   logic [1:0] ss_s;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sck_s <= '0;
         mosi_s <= '0;
         miso_s <= '0;
         ss_s <= 2'h3;
      end else if (I_CE) begin
         sck_s <= {sck_s[0], I_SCK};
         mosi_s <= {mosi_s[0], I_MOSI};
         miso_s <= {miso_s[0], I_MISO};
         ss_s <= {ss_s[0], I_SS_N};
      end
   end
   logic sck_d_reg;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         sck_d_reg <= 1'b0;
      end else if (I_CE) begin
         sck_d_reg <= sck_s[1];
      end
   end

   logic en;
   logic mst;
   logic ss_auto;
   logic ss_fault_in;
   assign en = I_CFG.module_enable;
   assign mst = I_CFG.master_mode;
   assign ss_auto = mst && I_CFG.mode_fault_enable
      && I_CFG.select_output_enable;
   assign ss_fault_in = mst && I_CFG.mode_fault_enable
      && !I_CFG.select_output_enable;

   // ==========================================================
   // Transmit buffer
   // ==========================================================
   logic tx_valid;
   logic tx_pop;
   logic [DW-1:0] tx_data;
   spi_fifo #(.WIDTH(DW), .DEPTH(FIFO_D)) u_txbuf (
      .clk(I_CLK),
      .rst_n(I_RST_N),
      .ce(I_CE),
      .flush(!en),
      .i_valid(I_WR && en),
      .o_ready(O_TX_READY),
      .i_data(I_WDATA),
      .o_valid(tx_valid),
      .i_ready(tx_pop),
      .o_data(tx_data)
   );
   assign O_TX_EMPTY = !tx_valid;

   // ==========================================================
   // Master bit clock generator
   // ==========================================================
   // Divisor = (prescale+1) * 2^(rate+1); tick marks each half period
   logic [2:0] pre_reg;
   logic [7:0] rate_reg;
   logic half_tick;
   logic pre_tick;
   logic [7:0] rate_top;
   assign pre_tick = (pre_reg == I_CFG.prescale_select);
   assign rate_top = 8'(({8'h00, 1'b1} << I_CFG.rate_select) - 1'b1);
   assign half_tick = pre_tick && (rate_reg == rate_top);

   spi_port_pkg::xfer_state_t st_reg;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N
         || (I_CE && (!en || st_reg == spi_port_pkg::ST_IDLE))) begin
         pre_reg <= '0;
         rate_reg <= '0;
      end else if (I_CE) begin
         pre_reg <= pre_tick ? '0 : pre_reg + 1'b1;
         if (pre_tick) begin
            rate_reg <= (rate_reg == rate_top) ? '0 : rate_reg + 1'b1;
         end
      end
   end

   // ==========================================================
   // Shift engine
   // ==========================================================
   logic [DW-1:0] shift_reg;
   logic [CW-1:0] cnt_reg;
   logic [DW-1:0] rx_reg;
   logic rx_full_reg;
   logic fault_reg;
   logic sck_reg;
   logic sdi;
   logic slv_sel;
   logic slv_rise;
   logic slv_fall;
   logic done;

   // Input routing by role and wiring mode
   always_comb begin
      if (mst) begin
         sdi = I_CFG.single_wire_select ? mosi_s[1] : miso_s[1];
      end else begin
         sdi = I_CFG.single_wire_select ? miso_s[1] : mosi_s[1];
      end
   end
   assign slv_sel = !mst && !ss_s[1];
   assign slv_rise = slv_sel && sck_s[1] && !sck_d_reg;
   assign slv_fall = slv_sel && !sck_s[1] && sck_d_reg;
   assign done = (cnt_reg == spi_port_pkg::BITS_PER_XFER);
   // Slave loads when idle and selected; master only starts with data queued
   assign tx_pop = I_CE && en && st_reg == spi_port_pkg::ST_IDLE
      && (mst ? (tx_valid && !fault_reg) : (slv_sel && tx_valid));

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || (I_CE && !en)) begin
         st_reg <= spi_port_pkg::ST_IDLE;
         shift_reg <= spi_port_pkg::DATA_RST;
         cnt_reg <= '0;
         sck_reg <= 1'b0;
      end else if (I_CE) begin
         unique case (st_reg)
            spi_port_pkg::ST_IDLE: begin
               sck_reg <= 1'b0;
               cnt_reg <= '0;
               if (tx_pop) begin
                  shift_reg <= tx_data;
                  st_reg <= spi_port_pkg::ST_LEAD;
               end else if (!mst && slv_sel) begin
                  shift_reg <= '1;
                  st_reg <= spi_port_pkg::ST_LEAD;
               end
            end
            spi_port_pkg::ST_LEAD: begin
               // Sample on leading (rising) edge
               if (mst && half_tick) begin
                  sck_reg <= 1'b1;
                  cnt_reg <= cnt_reg + 1'b1;
                  st_reg <= spi_port_pkg::ST_TRAIL;
               end else if (slv_rise) begin
                  shift_reg <= {shift_reg[DW-2:0], sdi};
                  cnt_reg <= cnt_reg + 1'b1;
                  st_reg <= spi_port_pkg::ST_TRAIL;
               end else if (!mst && !slv_sel) begin
                  st_reg <= spi_port_pkg::ST_IDLE;
               end
            end
            spi_port_pkg::ST_TRAIL: begin
               if ((mst && half_tick) || slv_fall || (!mst && !slv_sel)
                  || (!mst && done)) begin
                  sck_reg <= 1'b0;
                  // Master data changes on the falling edge only
                  if (mst) begin
                     shift_reg <= {shift_reg[DW-2:0], 1'b0};
                  end
                  st_reg <= (done || (!mst && !slv_sel))
                     ? spi_port_pkg::ST_IDLE : spi_port_pkg::ST_LEAD;
               end
            end
            default: st_reg <= spi_port_pkg::ST_IDLE;
         endcase
      end
   end

   // Receive buffer and flags
   // Synchronised input lags two clocks: master takes each bit two
   // clocks after its rise, so clock/2 still works
   logic m_rise;
   logic cap_now;
   logic [1:0] rise_pipe_reg;
   logic [CW-1:0] cap_cnt_reg;
   logic [DW-1:0] cap_reg;
   logic [DW-1:0] rx_word;
   logic xfer_end;
   assign m_rise = mst && st_reg == spi_port_pkg::ST_LEAD && half_tick;
   assign cap_now = I_CE && rise_pipe_reg[1];
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || (I_CE && !en)) begin
         rise_pipe_reg <= '0;
         cap_cnt_reg <= '0;
         cap_reg <= spi_port_pkg::DATA_RST;
      end else if (I_CE) begin
         rise_pipe_reg <= {rise_pipe_reg[0], m_rise};
         if (cap_now) begin
            cap_reg <= {cap_reg[DW-2:0], sdi};
            cap_cnt_reg <= (cap_cnt_reg == spi_port_pkg::BITS_PER_XFER
               - 1'b1) ? '0 : cap_cnt_reg + 1'b1;
         end
      end
   end
   assign xfer_end = mst
      ? cap_now && cap_cnt_reg == spi_port_pkg::BITS_PER_XFER - 1'b1
      : I_CE && st_reg == spi_port_pkg::ST_TRAIL && done;
   assign rx_word = mst ? {cap_reg[DW-2:0], sdi} : shift_reg;
   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || (I_CE && !en)) begin
         rx_reg <= spi_port_pkg::DATA_RST;
         rx_full_reg <= 1'b0;
      end else if (I_CE) begin
         if (xfer_end) begin
            rx_reg <= rx_word;
            rx_full_reg <= 1'b1;
         end else if (I_RD) begin
            rx_full_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || (I_CE && !en)) begin
         fault_reg <= 1'b0;
      end else if (I_CE && ss_fault_in && !ss_s[1]) begin
         fault_reg <= 1'b1;
      end
   end

   assign O_RDATA = rx_reg;
   assign O_RX_FULL = rx_full_reg;
   assign O_MODE_FAULT = fault_reg;
   assign O_BUSY = (st_reg != spi_port_pkg::ST_IDLE);

   // ==========================================================
   // Pin multiplexing
   // ==========================================================
   logic sdo;
   assign sdo = shift_reg[DW-1];
   always_comb begin
      O_SCK = sck_reg;
      O_SCK_OE = en && mst;
      O_MOSI = sdo;
      O_MISO = sdo;
      O_MOSI_OE = 1'b0;
      O_MISO_OE = 1'b0;
      if (en && mst) begin
         O_MOSI_OE = I_CFG.single_wire_select
            ? I_CFG.bidir_output_enable : 1'b1;
      end else if (en) begin
         O_MISO_OE = slv_sel && (I_CFG.single_wire_select
            ? I_CFG.bidir_output_enable : 1'b1);
      end
      O_SS_N = !O_BUSY;
      O_SS_N_OE = en && ss_auto;
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_master_start;
      st_reg == spi_port_pkg::ST_IDLE && tx_pop && mst;
   endsequence

   a_pins_released: assert property (
      !en |-> !O_SCK_OE && !O_MOSI_OE && !O_MISO_OE && !O_SS_N_OE)
      else $error("pins driven while disabled");
   a_disable_flush: assert property (
      I_CE && !en |=> !O_RX_FULL && O_TX_EMPTY && !O_BUSY)
      else $error("disable did not clear state");
   a_start_load: assert property (
      s_master_start |=> shift_reg == $past(tx_data))
      else $error("transmit byte not loaded");
   a_rx_capture: assert property (
      xfer_end |=> O_RX_FULL && O_RDATA == $past(rx_word))
      else $error("receive buffer not filled");
   a_auto_select: assert property (
      en && ss_auto |-> O_SS_N == (st_reg == spi_port_pkg::ST_IDLE))
      else $error("select output wrong");
   a_master_min: assert property (
      en && mst && st_reg != spi_port_pkg::ST_IDLE && !half_tick
      |=> $stable(O_SCK))
      else $error("master bit clock moved off its divider tick");
   a_master_mux: assert property (
      en && mst && !I_CFG.single_wire_select |-> O_MOSI_OE && !O_MISO_OE)
      else $error("master data pins misrouted");
   a_single_wire: assert property (
      en && I_CFG.single_wire_select |-> (mst ? !O_MISO_OE : !O_MOSI_OE))
      else $error("unused data pin driven");
   a_slave_select: assert property (
      en && !mst && ss_s[1] |-> !O_MISO_OE)
      else $error("slave drives while deselected");
   a_fault_set: assert property (
      I_CE && en && ss_fault_in && !ss_s[1] |=> O_MODE_FAULT)
      else $error("mode fault not flagged");
endmodule

//--- spi_peer_model.sv
// Behavioural slave on the far side of the port, clock mode 0.
// Assumes the bench resolves every shared wire from all enables.
`timescale 1ns/1ps
module spi_peer_model (
   // Control
   input wire logic en,
   input wire logic [7:0] tx,
   output logic [7:0] rx,
   // Wires
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe
);
   logic [7:0] sh = 8'h00;
   initial rx = 8'h00;
   // Takes part only while selected low
   assign miso_oe = en && !ss_n;
   assign miso = sh[7];
   always @(negedge ss_n) if (en) sh <= tx;
   always @(posedge sck) if (miso_oe) rx <= {rx[6:0], mosi};
   always @(negedge sck) if (miso_oe) sh <= {sh[6:0], 1'b0};
endmodule

//--- spi_port_test.sv
// Self-checking bench for the serial peripheral port.
// Assumes the peer model file is compiled first.
`timescale 1ns/1ps
module spi_port_test;
   // ====================
   // Signals
   logic I_CLK = 1'b0;
   logic I_RST_N = 1'b0;
   logic I_CE = 1'b1;
   spi_port_pkg::cfg_t cfg = '0;
   logic I_WR = 1'b0;
   logic I_RD = 1'b0;
   logic [7:0] I_WDATA = 8'h00;
   logic [7:0] O_RDATA;
   logic O_TX_EMPTY, O_TX_READY, O_RX_FULL, O_MODE_FAULT, O_BUSY;
   logic O_SCK, O_SCK_OE, O_MOSI, O_MOSI_OE;
   logic O_MISO, O_MISO_OE, O_SS_N, O_SS_N_OE;
   logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss_n = 1'b1;
   logic peer_en = 1'b0, p_miso, p_oe, sck_d = 1'b0, ss_bad = 1'b0, s;
   logic [7:0] peer_tx = 8'h00, peer_rx, cap = 8'h00;
   int n_fail = 0, checks = 0, cyc = 0, rise_t = 0, per = 0;
   int pre[4] = '{0, 2, 7, 1};
   int rt[4] = '{0, 1, 0, 7};
   // A released MISO wire toggles so a stale value never passes
   wire sck_w = O_SCK_OE ? O_SCK : tb_sck;
   wire ss_w = O_SS_N_OE ? O_SS_N : tb_ss_n;
   wire mosi_w = O_MOSI_OE ? O_MOSI : tb_mosi;
   wire miso_w = O_MISO_OE ? O_MISO : p_oe ? p_miso : cyc[0];

   always #10 I_CLK = ~I_CLK;

   spi_port dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
      .I_CFG(cfg), .I_WR(I_WR), .I_WDATA(I_WDATA), .I_RD(I_RD),
      .O_RDATA(O_RDATA), .O_TX_EMPTY(O_TX_EMPTY),
      .O_TX_READY(O_TX_READY), .O_RX_FULL(O_RX_FULL),
      .O_MODE_FAULT(O_MODE_FAULT), .O_BUSY(O_BUSY),
      .I_SCK(sck_w), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE),
      .I_MOSI(mosi_w), .O_MOSI(O_MOSI), .O_MOSI_OE(O_MOSI_OE),
      .I_MISO(miso_w), .O_MISO(O_MISO), .O_MISO_OE(O_MISO_OE),
      .I_SS_N(ss_w), .O_SS_N(O_SS_N), .O_SS_N_OE(O_SS_N_OE));

   spi_peer_model peer (.en(peer_en), .tx(peer_tx), .rx(peer_rx),
      .sck(sck_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso),
      .miso_oe(p_oe));

   // ====================
   // Monitors and timeout
   always @(posedge I_CLK) begin
      cyc <= cyc + 1;
      sck_d <= O_SCK;
      if (O_SCK && !sck_d) begin
         per <= cyc - rise_t;
         rise_t <= cyc;
      end
      if (O_BUSY && cfg.master_mode && ss_w) ss_bad <= 1'b1;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish;
      end
   end

   // ====================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge I_CLK);
      #1;
   endtask

   task automatic wr(input logic [7:0] d);
      I_WR = 1'b1;
      I_WDATA = d;
      tick(1);
      I_WR = 1'b0;
      tick(1);
   endtask

   task automatic rd;
      I_RD = 1'b1;
      tick(1);
      I_RD = 1'b0;
      tick(1);
   endtask

   task automatic done;
      int k;
      k = 0;
      while (O_BUSY !== 1'b1 && k < 50) begin tick(1); k++; end
      k = 0;
      while (O_BUSY !== 1'b0 && k < 9000) begin tick(1); k++; end
      tick(3);
   endtask

   // Bench as master; half period of 4 clocks suits the slave filter
   task automatic sl_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tb_mosi = b[i];
         tick(4);
         tb_sck = 1'b1;
         cap = {cap[6:0], miso_w};
         tick(4);
         tb_sck = 1'b0;
      end
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, errors %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ====================
   // Sequence
   initial begin
      tick(20);
      I_RST_N = 1'b1;
      tick(1);
      chk("flags", 2'b10, {O_TX_EMPTY, O_RX_FULL});
      chk("pins_oe", 0, {O_SCK_OE, O_MOSI_OE, O_MISO_OE, O_SS_N_OE});
      cfg.module_enable = 1'b1;
      cfg.master_mode = 1'b1;
      cfg.mode_fault_enable = 1'b1;
      cfg.select_output_enable = 1'b1;
      peer_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         cfg.prescale_select = 3'(pre[i]);
         cfg.rate_select = 3'(rt[i]);
         peer_tx = 8'hA5 ^ 8'(i);
         tick(2);
         wr(8'h3C + 8'(i));
         if (i == 3) begin
            tick(100);
            s = O_SCK;
            I_CE = 1'b0;
            tick(30);
            chk("freeze_sck", s, O_SCK);
            chk("freeze_busy", 1, O_BUSY);
            I_CE = 1'b1;
         end
         done;
         chk("peer_rx", 8'h3C + 8'(i), peer_rx);
         chk("rdata", 8'hA5 ^ 8'(i), O_RDATA);
         chk("rx_full", 1, O_RX_FULL);
         chk("sck_period", (pre[i] + 1) << (rt[i] + 1), per);
         chk("ss_idle", 1, ss_w);
         chk("m_oe", 3'b110, {O_SCK_OE, O_MOSI_OE, O_MISO_OE});
         rd;
         chk("rx_clr", 0, O_RX_FULL);
      end
      chk("ss_low", 0, ss_bad);
      // Mode fault blocks starts, so writes pile up in the FIFO
      peer_en = 1'b0;
      cfg.mode_fault_enable = 1'b0;
      tb_ss_n = 1'b0;
      tick(4);
      chk("ss_gpio", 2'b00, {O_SS_N_OE, O_MODE_FAULT});
      cfg.mode_fault_enable = 1'b1;
      cfg.select_output_enable = 1'b0;
      tick(4);
      chk("mode_fault", 2'b01, {O_SS_N_OE, O_MODE_FAULT});
      I_WR = 1'b1;
      for (int k = 0; k < 5; k++) begin
         I_WDATA = 8'(k);
         tick(1);
      end
      I_WR = 1'b0;
      tick(1);
      chk("full_idle", 2'b00, {O_TX_READY, O_BUSY});
      cfg.module_enable = 1'b0;
      tick(2);
      chk("flush", 3'b100, {O_TX_EMPTY, O_RX_FULL, O_MODE_FAULT});
      cfg = '0;
      cfg.module_enable = 1'b1;
      cfg.master_mode = 1'b1;
      cfg.single_wire_select = 1'b1;
      tb_ss_n = 1'b1;
      tick(2);
      chk("sw_m_in", 2'b00, {O_MOSI_OE, O_MISO_OE});
      cfg.bidir_output_enable = 1'b1;
      tick(2);
      chk("sw_m_out", 2'b10, {O_MOSI_OE, O_MISO_OE});
      cfg.master_mode = 1'b0;
      tb_ss_n = 1'b0;
      tick(2);
      chk("sw_s_out", 2'b01, {O_MOSI_OE, O_MISO_OE});
      cfg.bidir_output_enable = 1'b0;
      tick(2);
      chk("sw_s_in", 2'b00, {O_MOSI_OE, O_MISO_OE});
      cfg.single_wire_select = 1'b0;
      tb_ss_n = 1'b1;
      tick(4);
      chk("s_sck_oe", 0, O_SCK_OE);
      wr(8'h96);
      tb_ss_n = 1'b0;
      tick(4);
      sl_byte(8'h5A);
      tick(2);
      tb_ss_n = 1'b1;
      tick(6);
      chk("s_rdata", 8'h5A, O_RDATA);
      chk("s_miso", 8'h96, cap);
      rd;
      sl_byte(8'hC3);
      tick(6);
      chk("s_unsel", 0, O_RX_FULL);
      tally_and_finish;
   end
endmodule
